// [pkg/option_map_pkg.sv]
// package: register map, reset values, field layout and carriers
package option_map_pkg;

  // ***********************************************************
  // register map
  // ***********************************************************
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CLAMP_ALLOC = 8'h00;
  localparam logic [7:0] OFS_BANK_LATCH_ALLOC = 8'h04;
  localparam logic [7:0] OFS_OUTPUT_ALLOC = 8'h08;
  localparam logic [7:0] OFS_RESTART = 8'h0C;
  localparam logic [7:0] OFS_FUNC_STATUS = 8'h10;

  // ***********************************************************
  // reset values
  // ***********************************************************
  localparam logic [15:0] RST_CLAMP_ALLOC = 16'h1F1E;
  localparam logic [15:0] RST_BANK_LATCH_ALLOC = 16'h0000;
  localparam logic [15:0] RST_OUTPUT_ALLOC = 16'h0000;

  // ***********************************************************
  // field layout: nibble positions inside allocation words
  // ***********************************************************
  localparam int POS_LO = 0;
  localparam int VALID_LO = 4;
  localparam int POS_HI = 8;
  localparam int VALID_HI = 12;
  localparam logic [3:0] MAP_VALID = 4'h1;
  localparam int RESTART_BIT = 0;
  localparam int BANK_W = 4;
  localparam int OUTSIG_W = 3;

  // ***********************************************************
  // carriers
  // ***********************************************************
  typedef struct packed {
    logic valid;
    logic [15:0] option;
  } option_cmd_t;

  typedef struct packed {
    logic positive_clamp_flag;
    logic negative_clamp_flag;
    logic [3:0] bank_selector;
    logic latch_off_flag;
    logic [2:0] out_signal;
  } func_out_t;

endpackage : option_map_pkg

// [core/field_extract.sv]
// module: pulls one mapped field out of the option word
`timescale 1ns/1ps
module field_extract #(
  parameter int W = 1
) (
  input wire logic [15:0] option,
  input wire logic [3:0] pos,
  input wire logic [3:0] valid_nib,
  output logic [W-1:0] val
);
  import option_map_pkg::*;

  logic [15:0] shifted;

  // a field running past bit 15 is treated as unmapped, not truncated
  always_comb begin
    shifted = option >> pos;
    if (valid_nib == MAP_VALID && ({1'b0, pos} <= 5'(16 - W))) begin
      val = shifted[W-1:0];
    end else begin
      val = '0;
    end
  end

endmodule : field_extract

// [core/option_field_bit_mapper.sv]
// module: option field decoder with boot-latched allocation words
//
// Summary of operation
// R01: the positive clamp flag follows its mapped option bit only while its validity nibble is 1.
// R02: the negative clamp flag follows its mapped option bit only while its validity nibble is 1.
// R03: the bank selector is four adjacent option bits whose lowest index is the position nibble, up to bits 12..15.
// R04: the bank selector mapping is used only while its validity nibble is 1 and ignored at 0.
// R05: the latch-off flag is the single option bit whose index 0..15 equals its position nibble.
// R06: the latch-off mapping is used only while its validity nibble is 1.
// R07: the output-signal field is three adjacent option bits starting at the position nibble.
// R08: the output-signal mapping is used only while its validity nibble is 1.
// R09: software keeps the two low nibbles of the output allocation word at their reserved values.
// R10: a disabled mapping drives its function inactive whatever the option bits carry.
// R11: allocation words take effect only at power-up; later writes wait for the next restart.
`timescale 1ns/1ps
module option_field_bit_mapper (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [option_map_pkg::ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata_r,
  input wire option_map_pkg::option_cmd_t cmd,
  output option_map_pkg::func_out_t func_r,
  output logic func_valid_r
);
  import option_map_pkg::*;

  // ***********************************************************
  // staged and active allocation words
  // ***********************************************************
  logic [15:0] stg_clamp_r;
  logic [15:0] stg_bank_r;
  logic [15:0] stg_out_r;
  logic [15:0] act_clamp_r;
  logic [15:0] act_bank_r;
  logic [15:0] act_out_r;
  logic boot_done_r;
  logic restart;
  func_out_t func_nxt;
  logic pclamp_v;
  logic nclamp_v;
  logic [BANK_W-1:0] bank_v;
  logic latch_v;
  logic [OUTSIG_W-1:0] outsig_v;

  assign restart = wr && addr == OFS_RESTART && wdata[RESTART_BIT];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stg_clamp_r <= RST_CLAMP_ALLOC;
      stg_bank_r <= RST_BANK_LATCH_ALLOC;
      stg_out_r <= RST_OUTPUT_ALLOC;
    end else if (wr) begin
      // reserved low nibbles of the output word are stored as written
      case (addr)
        OFS_CLAMP_ALLOC: stg_clamp_r <= wdata[15:0];
        OFS_BANK_LATCH_ALLOC: stg_bank_r <= wdata[15:0];
        OFS_OUTPUT_ALLOC: stg_out_r <= wdata[15:0];
        default: ;
      endcase
    end
  end

  // the active copy loads once after reset release, or on a restart
  // command that stands in for a power cycle; staged writes never
  // reach the decoder directly so a live command sees a stable map
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      act_clamp_r <= RST_CLAMP_ALLOC;
      act_bank_r <= RST_BANK_LATCH_ALLOC;
      act_out_r <= RST_OUTPUT_ALLOC;
      boot_done_r <= 1'b0;
    end else begin
      boot_done_r <= 1'b1;
      if (!boot_done_r || restart) begin // R11
        act_clamp_r <= stg_clamp_r;
        act_bank_r <= stg_bank_r;
        act_out_r <= stg_out_r;
      end
    end
  end

  // ***********************************************************
  // field decode
  // ***********************************************************
  field_extract #(.W(1)) pclamp_x (
    .option(cmd.option),
    .pos(act_clamp_r[POS_LO+:4]),
    .valid_nib(act_clamp_r[VALID_LO+:4]),
    .val(pclamp_v)
  ); // R01 R10
  field_extract #(.W(1)) nclamp_x (
    .option(cmd.option),
    .pos(act_clamp_r[POS_HI+:4]),
    .valid_nib(act_clamp_r[VALID_HI+:4]),
    .val(nclamp_v)
  ); // R02 R10
  field_extract #(.W(BANK_W)) bank_x (
    .option(cmd.option),
    .pos(act_bank_r[POS_LO+:4]),
    .valid_nib(act_bank_r[VALID_LO+:4]),
    .val(bank_v)
  ); // R03 R04 R10
  field_extract #(.W(1)) latch_x (
    .option(cmd.option),
    .pos(act_bank_r[POS_HI+:4]),
    .valid_nib(act_bank_r[VALID_HI+:4]),
    .val(latch_v)
  ); // R05 R06 R10
  field_extract #(.W(OUTSIG_W)) outsig_x (
    .option(cmd.option),
    .pos(act_out_r[POS_HI+:4]),
    .valid_nib(act_out_r[VALID_HI+:4]),
    .val(outsig_v)
  ); // R07 R08 R10

  // one process builds the carrier so it has a single driver
  always_comb begin
    func_nxt = '0;
    func_nxt.positive_clamp_flag = pclamp_v;
    func_nxt.negative_clamp_flag = nclamp_v;
    func_nxt.bank_selector = bank_v;
    func_nxt.latch_off_flag = latch_v;
    func_nxt.out_signal = outsig_v;
  end

  // functions hold between commands; each command replaces them all
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      func_r <= '0;
      func_valid_r <= 1'b0;
    end else begin
      func_valid_r <= cmd.valid;
      if (cmd.valid) begin
        func_r <= func_nxt;
      end
    end
  end

  // ***********************************************************
  // register read port
  // ***********************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= '0;
    end else if (rd) begin
      case (addr)
        OFS_CLAMP_ALLOC: rdata_r <= {16'h0000, stg_clamp_r};
        OFS_BANK_LATCH_ALLOC: rdata_r <= {16'h0000, stg_bank_r};
        OFS_OUTPUT_ALLOC: rdata_r <= {16'h0000, stg_out_r};
        OFS_FUNC_STATUS: rdata_r <= {22'h000000, func_r};
        default: rdata_r <= '0;
      endcase
    end else begin
      rdata_r <= '0;
    end
  end

  // ***********************************************************
  // assertions
  // ***********************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  pclamp_route_a: assert property ( // R01
    cmd.valid && act_clamp_r[VALID_LO+:4] == MAP_VALID |=>
      func_r.positive_clamp_flag ==
      $past(cmd.option[act_clamp_r[POS_LO+:4]]))
    else $error("positive clamp not taken from mapped bit");

  nclamp_route_a: assert property ( // R02
    cmd.valid && act_clamp_r[VALID_HI+:4] == MAP_VALID |=>
      func_r.negative_clamp_flag ==
      $past(cmd.option[act_clamp_r[POS_HI+:4]]))
    else $error("negative clamp not taken from mapped bit");

  bank_field_a: assert property ( // R03
    cmd.valid && act_bank_r[VALID_LO+:4] == MAP_VALID &&
      act_bank_r[POS_LO+:4] <= 4'hC |=>
      func_r.bank_selector ==
      $past(4'(cmd.option >> act_bank_r[POS_LO+:4])))
    else $error("bank selector field misplaced");

  bank_gate_a: assert property ( // R04
    cmd.valid && act_bank_r[VALID_LO+:4] != MAP_VALID |=>
      func_r.bank_selector == 4'h0)
    else $error("bank selector used while disabled");

  latch_route_a: assert property ( // R05
    cmd.valid && act_bank_r[VALID_HI+:4] == MAP_VALID |=>
      func_r.latch_off_flag == $past(cmd.option[act_bank_r[POS_HI+:4]]))
    else $error("latch-off flag not taken from mapped bit");

  latch_gate_a: assert property ( // R06
    cmd.valid && act_bank_r[VALID_HI+:4] != MAP_VALID |=>
      !func_r.latch_off_flag)
    else $error("latch-off flag used while disabled");

  outsig_field_a: assert property ( // R07
    cmd.valid && act_out_r[VALID_HI+:4] == MAP_VALID &&
      act_out_r[POS_HI+:4] <= 4'hD |=>
      func_r.out_signal == $past(3'(cmd.option >> act_out_r[POS_HI+:4])))
    else $error("output-signal field misplaced");

  outsig_gate_a: assert property ( // R08
    cmd.valid && act_out_r[VALID_HI+:4] != MAP_VALID |=>
      func_r.out_signal == 3'h0)
    else $error("output-signal field used while disabled");

  clamp_idle_a: assert property ( // R10
    cmd.valid && act_clamp_r[VALID_LO+:4] != MAP_VALID &&
      act_clamp_r[VALID_HI+:4] != MAP_VALID |=>
      !func_r.positive_clamp_flag && !func_r.negative_clamp_flag)
    else $error("disabled clamp driven active");

  boot_only_a: assert property ( // R11
    boot_done_r && !restart |=>
      act_clamp_r == $past(act_clamp_r) &&
      act_bank_r == $past(act_bank_r) && act_out_r == $past(act_out_r))
    else $error("allocation changed without restart");

  pclamp_live_c: cover property (
    cmd.valid && act_clamp_r[VALID_LO+:4] == MAP_VALID ##1
      func_r.positive_clamp_flag);
  bank_top_c: cover property (
    cmd.valid && act_bank_r[VALID_LO+:4] == MAP_VALID &&
      act_bank_r[POS_LO+:4] == 4'hC);
  restart_c: cover property (restart ##1 boot_done_r);
  outsig_c: cover property (
    cmd.valid && act_out_r[VALID_HI+:4] == MAP_VALID ##1
      func_r.out_signal != 3'h0);

endmodule : option_field_bit_mapper

// [testbench/option_host.sv]
// partner model: host motion controller issuing option commands
`timescale 1ns/1ps
module option_host (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic send,
  input wire logic [15:0] word,
  output option_map_pkg::option_cmd_t cmd
);
  import option_map_pkg::*;
  // ********************
  // command driver
  // ********************
  // idle cycles invert the option bits, so a stale word comes back on every second idle cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd <= '0;
    end else if (send) begin
      cmd.valid <= 1'b1;
      cmd.option <= word;
    end else begin
      cmd.valid <= 1'b0;
      cmd.option <= ~cmd.option;
    end
  end
endmodule : option_host

// [testbench/option_field_bit_mapper_test.sv]
// testbench: register access, restart latching and option decoding
`timescale 1ns/1ps
module option_field_bit_mapper_test;
  import option_map_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic send = 1'b0;
  logic [15:0] word = 16'h0000;
  logic [31:0] rdata_r;
  option_cmd_t cmd;
  func_out_t func_r;
  logic func_valid_r;
  int mismatches = 0;
  int n_compared = 0;
  logic [15:0] cw, bw, ow, ac, ab, ao;
  logic [3:0] bad [3] = '{4'h0, 4'h2, 4'hF};

  option_field_bit_mapper dut_u (.clk(clk), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata_r(rdata_r), .cmd(cmd),
    .func_r(func_r), .func_valid_r(func_valid_r));
  option_host host_u (.clk(clk), .rst_n(rst_n), .send(send), .word(word),
    .cmd(cmd));

  initial begin
    forever #2.5 clk = ~clk;
  end

  // ********************
  // access tasks
  // ********************
  task automatic chk(input string what, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= {16'h0000, d};
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                        input string what);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(what, e, rdata_r);
  endtask : rd_chk

  // staged words read back at once, decode waits for restart
  task automatic cfg(input logic [15:0] c, b, o);
    cw = c;
    bw = b;
    ow = o;
    wr_reg(OFS_CLAMP_ALLOC, c);
    wr_reg(OFS_BANK_LATCH_ALLOC, b);
    wr_reg(OFS_OUTPUT_ALLOC, o);
    rd_chk(OFS_CLAMP_ALLOC, {16'h0, c}, "clamp word");
    rd_chk(OFS_BANK_LATCH_ALLOC, {16'h0, b}, "bank word");
    rd_chk(OFS_OUTPUT_ALLOC, {16'h0, o}, "output word");
  endtask : cfg

  task automatic restart();
    wr_reg(OFS_RESTART, 16'h0001);
    ac = cw;
    ab = bw;
    ao = ow;
  endtask : restart

  function automatic func_out_t expect_of(input logic [15:0] o);
    func_out_t f;
    logic [15:0] sb, so;
    f = '0;
    sb = o >> ab[3:0];
    so = o >> ao[11:8];
    if (ac[7:4] == 4'h1) f.positive_clamp_flag = o[ac[3:0]];
    if (ac[15:12] == 4'h1) f.negative_clamp_flag = o[ac[11:8]];
    if (ab[7:4] == 4'h1 && ab[3:0] <= 4'hC) f.bank_selector = sb[3:0];
    if (ab[15:12] == 4'h1) f.latch_off_flag = o[ab[11:8]];
    if (ao[15:12] == 4'h1 && ao[11:8] <= 4'hD) f.out_signal = so[2:0];
    return f;
  endfunction : expect_of

  task automatic send_chk(input logic [15:0] o, input string what);
    func_out_t e;
    e = expect_of(o);
    @(posedge clk);
    send <= 1'b1;
    word <= o;
    @(posedge clk);
    send <= 1'b0;
    @(posedge clk);
    #1 chk(what, {22'h0, e}, {22'h0, func_r});
    chk("valid high", 32'h1, {31'h0, func_valid_r});
    @(posedge clk);
    #1 chk("valid low", 32'h0, {31'h0, func_valid_r});
    chk("func held", {22'h0, e}, {22'h0, func_r});
  endtask : send_chk

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results

  // ********************
  // tests
  // ********************
  initial begin
    #200000;
    mismatches++;
    $display("Error watchdog expected finish seen hang");
    results();
  end

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    ac = RST_CLAMP_ALLOC;
    ab = RST_BANK_LATCH_ALLOC;
    ao = RST_OUTPUT_ALLOC;
    rd_chk(OFS_CLAMP_ALLOC, {16'h0, RST_CLAMP_ALLOC}, "clamp reset");
    rd_chk(OFS_BANK_LATCH_ALLOC, 32'h0, "bank reset");
    rd_chk(OFS_OUTPUT_ALLOC, 32'h0, "output reset");
    wr_reg(8'h14, 16'hFFFF);
    rd_chk(8'h14, 32'h0, "unmapped");
    rd_chk(OFS_RESTART, 32'h0, "restart reads");
    send_chk(16'hFFFF, "reset decode");
    send_chk(16'h4000, "positive only");
    $display("test reset_map done");
    for (int p = 0; p < 16; p++) begin
      cfg({4'h1, 4'(15 - p), 4'h1, 4'(p)}, {4'h1, 4'(p ^ 7), 4'h1, 4'(p)},
          {4'h1, 4'(p), 8'h00});
      send_chk(16'hA5C3, "old map held");
      restart();
      send_chk(16'hA5C3, "mapped a");
      send_chk(16'h5A3C ^ 16'(p), "mapped b");
    end
    $display("test positions done");
    for (int i = 0; i < 3; i++) begin
      cfg({bad[i], 4'hE, bad[i], 4'h3}, {bad[i], 4'h2, bad[i], 4'h1},
          {bad[i], 4'h4, 8'h00});
      restart();
      send_chk(16'hFFFF, "disabled map");
    end
    rd_chk(OFS_FUNC_STATUS, {22'h0, expect_of(16'hFFFF)}, "status");
    $display("test validity done");
    results();
  end
endmodule : option_field_bit_mapper_test
